// file: design/adtc_cmp_unit.v
`timescale 1ns/1ps
`include "adtc_defines.vh"

module adtc_cmp_unit #(
   parameter [0:0] ALLOW_BATT = 1'b0
) (
   input wire sys_clk,
   input wire rst,
   input wire on,
   input wire [15:0] setup,
   input wire result_valid,
   input wire [2:0] result_source,
   input wire [11:0] result_data,
   output reg hit_flag_q,
   output reg hit_pulse_q
);

   // legal source codes; code 0 only where the battery is wired
   function src_legal;
      input [2:0] code;
      input allow_batt;
      begin
         case (code)
            `ADTC_SRC_GPIO10, `ADTC_SRC_GPIO11, `ADTC_SRC_GPIO12,
            `ADTC_SRC_TEMP, `ADTC_SRC_SUPPLY: src_legal = 1'b1;
            `ADTC_SRC_BATT: src_legal = allow_batt;
            default: src_legal = 1'b0;
         endcase
      end
   endfunction

   wire [2:0] sel = setup[`ADTC_SRC_HI:`ADTC_SRC_LO];
   wire [11:0] thr = setup[`ADTC_THR_HI:`ADTC_THR_LO];
   // reserved selections never match any result
   wire src_match = result_valid & src_legal(sel, ALLOW_BATT) &
      (result_source == sel);
   // unsigned compare, direction picks below or at-or-above
   wire met = setup[`ADTC_DIR_BIT] ? (result_data >= thr) :
      (result_data < thr);

   // flag follows the latest matching result; pulse marks a detection
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hit_flag_q <= 1'b0;
         hit_pulse_q <= 1'b0;
      end else if (!on) begin
         hit_flag_q <= 1'b0;
         hit_pulse_q <= 1'b0;
      end else begin
         hit_pulse_q <= src_match & met;
         if (src_match) begin
            hit_flag_q <= met;
         end
      end
   end

endmodule // adtc_cmp_unit

// file: design/adtc_defines.vh
`ifndef ADTC_DEFINES_VH
`define ADTC_DEFINES_VH

// --------------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------------
`define ADTC_IDX_CTRL 16'h4030
`define ADTC_IDX_CMP1 16'h4031
`define ADTC_IDX_CMP2 16'h4032
`define ADTC_IDX_CMP3 16'h4033
`define ADTC_IDX_CMP4 16'h4034
`define ADTC_IDX_IRQ_STAT 16'h4035
`define ADTC_IDX_IRQ_EN 16'h4036
`define ADTC_IDX_IRQ_CLR 16'h4037

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define ADTC_SRC_HI 15
`define ADTC_SRC_LO 13
`define ADTC_DIR_BIT 12
`define ADTC_THR_HI 11
`define ADTC_THR_LO 0
`define ADTC_CTRL_STS_LO 8
`define ADTC_CTRL_STS_HI 11
`define ADTC_CTRL_ENA_LO 0
`define ADTC_CTRL_ENA_HI 3

// --------------------------------------------------------------------
// source codes
// --------------------------------------------------------------------
`define ADTC_SRC_BATT 3'h0
`define ADTC_SRC_GPIO10 3'h1
`define ADTC_SRC_GPIO11 3'h2
`define ADTC_SRC_GPIO12 3'h3
`define ADTC_SRC_TEMP 3'h5
`define ADTC_SRC_SUPPLY 3'h7

// --------------------------------------------------------------------
// reset values and bus timing
// --------------------------------------------------------------------
`define ADTC_CFG_RST 16'h0000
`define ADTC_NIB_RST 4'h0
`define ADTC_WAIT_CYCLES 1

`endif

// file: design/adtc_evt_irq.v
`timescale 1ns/1ps
`include "adtc_defines.vh"

module adtc_evt_irq (
   input wire sys_clk,
   input wire rst,
   input wire [3:0] event_pulse,
   input wire [3:0] clear_bits,
   input wire clear_write,
   input wire [3:0] enable_d,
   input wire enable_write,
   output reg [3:0] status_q,
   output reg [3:0] enable_q,
   output wire irq
);

   // sticky status; an event in the clear cycle survives the clear
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_q <= `ADTC_NIB_RST;
      end else if (clear_write) begin
         status_q <= (status_q & ~clear_bits) | event_pulse;
      end else begin
         status_q <= status_q | event_pulse;
      end
   end

   // interrupt enable mask
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enable_q <= `ADTC_NIB_RST;
      end else if (enable_write) begin
         enable_q <= enable_d;
      end
   end

   assign irq = |(status_q & enable_q);

endmodule // adtc_evt_irq

// file: design/adtc_top.v
// Notes on behaviour
// - Comparators one to three pick GPIO10/11/12, chip temperature or supply by codes 1,2,3,5,7 in bits 15:13; 0, 4, 6 select nothing.
// - Comparator four uses the same codes but code 0 selects the backup battery.
// - Direction bit 12 at 0 flags a result strictly below the threshold, at 1 a result at or above it.
// - Each comparator holds a 12-bit unsigned threshold in bits 11:0 compared unsigned with the result.
// - Four comparators each with own source, direction and threshold, all zero after reset.
// - Control bits 3:0 enable comparators four to one, reset disabled; a disabled one neither evaluates nor flags.
// - Control bits 11:8 show for comparators four to one whether the chosen condition was met.
`timescale 1ns/1ps
`include "adtc_defines.vh"

module adtc_top (
   input wire sys_clk,
   input wire rst,
   input wire [17:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire adc_result_valid,
   input wire [2:0] adc_result_source,
   input wire [11:0] adc_result_data,
   output wire irq
);

   // --------------------------------------------------------------------
   // register storage
   // --------------------------------------------------------------------
   reg [15:0] cfg_q [0:3];
   reg [3:0] cmp_on_q;
   reg ack_q;
   wire [3:0] hit_flag;
   wire [3:0] hit_pulse;
   wire [3:0] irq_status;
   wire [3:0] irq_enable;

   wire [15:0] idx = avs_address[17:2];
   wire req = avs_read | avs_write;
   // write commits on the edge where waitrequest is low
   wire wr_go = avs_write & ack_q;
   // read data is captured one edge before it is presented
   wire rd_load = avs_read & ~ack_q;

   // byte-lane merge for the 16-bit registers; upper lanes ignored
   function [15:0] lane_merge;
      input [15:0] old_val;
      input [31:0] wdata;
      input [3:0] be;
      begin
         lane_merge[7:0] = be[0] ? wdata[7:0] : old_val[7:0];
         lane_merge[15:8] = be[1] ? wdata[15:8] : old_val[15:8];
      end
   endfunction

   // index of a comparator setup register, or 3'h4 if none
   function [2:0] cmp_slot;
      input [15:0] a;
      begin
         case (a)
            `ADTC_IDX_CMP1: cmp_slot = 3'h0;
            `ADTC_IDX_CMP2: cmp_slot = 3'h1;
            `ADTC_IDX_CMP3: cmp_slot = 3'h2;
            `ADTC_IDX_CMP4: cmp_slot = 3'h3;
            default: cmp_slot = 3'h4;
         endcase
      end
   endfunction

   wire [2:0] slot = cmp_slot(idx);

   // --------------------------------------------------------------------
   // bus handshake
   // --------------------------------------------------------------------
   // one wait state per access; ack drops after the accepting edge so a
   // held request is not taken again until after a fresh wait state
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   assign avs_waitrequest = req & ~ack_q;

   // --------------------------------------------------------------------
   // comparator setup registers
   // --------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cfg
         // each comparator keeps its own source, direction, threshold
         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               cfg_q[gi] <= `ADTC_CFG_RST;
            end else if (wr_go && slot == gi) begin
               cfg_q[gi] <= lane_merge(cfg_q[gi], avs_writedata,
                  avs_byteenable);
            end
         end
      end
   endgenerate

   // --------------------------------------------------------------------
   // control register: enables writable, flags read-only
   // --------------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmp_on_q <= `ADTC_NIB_RST;
      end else if (wr_go && idx == `ADTC_IDX_CTRL && avs_byteenable[0]) begin
         cmp_on_q <= avs_writedata[`ADTC_CTRL_ENA_HI:`ADTC_CTRL_ENA_LO];
      end
   end

   // --------------------------------------------------------------------
   // comparators
   // --------------------------------------------------------------------
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
         // only the fourth unit has the battery wired to code 0
         adtc_cmp_unit #(
            .ALLOW_BATT((gi == 3) ? 1'b1 : 1'b0)
         ) u_cmp (
            .sys_clk(sys_clk),
            .rst(rst),
            .on(cmp_on_q[gi]),
            .setup(cfg_q[gi]),
            .result_valid(adc_result_valid),
            .result_source(adc_result_source),
            .result_data(adc_result_data),
            .hit_flag_q(hit_flag[gi]),
            .hit_pulse_q(hit_pulse[gi])
         );
      end
   endgenerate

   // --------------------------------------------------------------------
   // interrupt status, enable and clear
   // --------------------------------------------------------------------
   adtc_evt_irq u_irq (
      .sys_clk(sys_clk),
      .rst(rst),
      .event_pulse(hit_pulse),
      .clear_bits(avs_writedata[3:0]),
      .clear_write(wr_go && idx == `ADTC_IDX_IRQ_CLR && avs_byteenable[0]),
      .enable_d(avs_writedata[3:0]),
      .enable_write(wr_go && idx == `ADTC_IDX_IRQ_EN && avs_byteenable[0]),
      .status_q(irq_status),
      .enable_q(irq_enable),
      .irq(irq)
   );

   // --------------------------------------------------------------------
   // read data
   // --------------------------------------------------------------------
   // unmapped and write-only locations read as zero
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (idx)
         `ADTC_IDX_CTRL: begin
            rd_mux[`ADTC_CTRL_STS_HI:`ADTC_CTRL_STS_LO] = hit_flag;
            rd_mux[`ADTC_CTRL_ENA_HI:`ADTC_CTRL_ENA_LO] = cmp_on_q;
         end
         `ADTC_IDX_CMP1: rd_mux[15:0] = cfg_q[0];
         `ADTC_IDX_CMP2: rd_mux[15:0] = cfg_q[1];
         `ADTC_IDX_CMP3: rd_mux[15:0] = cfg_q[2];
         `ADTC_IDX_CMP4: rd_mux[15:0] = cfg_q[3];
         `ADTC_IDX_IRQ_STAT: rd_mux[3:0] = irq_status;
         `ADTC_IDX_IRQ_EN: rd_mux[3:0] = irq_enable;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // data is registered so it stands steady on the accepting edge
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_load) begin
         avs_readdata <= rd_mux;
      end
   end

endmodule // adtc_top

// file: verif/adtc_adc_model.sv
`timescale 1ns/1ps

// stand-in for the result sequencer: one-cycle result pulses
module adtc_adc_model (
   output logic valid,
   output logic [2:0] source,
   output logic [11:0] data,
   input wire logic sys_clk
);
   initial begin
      valid = 1'b0;
      source = 3'h4;
      data = 12'h000;
   end

   // source and data are scrambled after the pulse so that a stale
   // value can never be mistaken for a fresh result
   task send(input logic [2:0] s, input logic [11:0] d);
      begin
         @(posedge sys_clk);
         valid <= 1'b1;
         source <= s;
         data <= d;
         @(posedge sys_clk);
         valid <= 1'b0;
         source <= ~s;
         data <= ~d;
      end
   endtask
endmodule // adtc_adc_model

// file: verif/adtc_chk.sv
`timescale 1ns/1ps

module adtc_chk (
   input wire sys_clk,
   input wire rst,
   input wire [17:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire adc_result_valid,
   input wire irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // read acknowledged in this cycle
   wire rd_ack = avs_read && !avs_waitrequest;

   a_wait_first: assert property (
      $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
      else $error("no wait state on new request");
   a_wait_one: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait state");
   a_rd_upper: assert property (
      rd_ack |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_rd_unmapped: assert property (
      rd_ack && avs_address[17:2] > 16'h4037 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_rd_clear: assert property (
      rd_ack && avs_address[17:2] == 16'h4037 |-> avs_readdata == 32'h0)
      else $error("clear register read not zero");
   a_rd_hold: assert property (
      !avs_read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   a_irq_cause: assert property (
      $rose(irq) |-> $past(adc_result_valid) || $past(adc_result_valid, 2)
         || $past(avs_write))
      else $error("interrupt rose without a result or write");
   a_irq_drop: assert property (
      $fell(irq) |-> $past(avs_write))
      else $error("interrupt fell without a write");

   cover property (rd_ack);
   cover property ($rose(irq));
   cover property (avs_write && !avs_waitrequest);
endmodule // adtc_chk

bind adtc_top adtc_chk u_chk (.sys_clk(sys_clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .adc_result_valid(adc_result_valid), .irq(irq));

// file: verif/adtc_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end

module adtc_top_test;
   logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq, adc_valid;
   logic [17:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [2:0] adc_src;
   logic [11:0] adc_data;
   logic [15:0] q;
   logic e;
   int n_errors = 0, n_checks = 0, i, k;
   // direction, threshold, result; expected outcome in dexp
   logic [24:0] dt [6] = '{{1'b0, 12'h800, 12'h7ff}, {1'b0, 12'h800, 12'h800},
      {1'b1, 12'h800, 12'h800}, {1'b1, 12'h800, 12'h7ff},
      {1'b1, 12'hfff, 12'hfff}, {1'b0, 12'h000, 12'h000}};
   logic [5:0] dexp = 6'b010101;

   adtc_top i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .adc_result_valid(adc_valid),
      .adc_result_source(adc_src), .adc_result_data(adc_data), .irq(irq));
   adtc_adc_model u_adc (.valid(adc_valid), .source(adc_src),
      .data(adc_data), .sys_clk(sys_clk));

   // ---------------------------------------------------------------
   // bus access and checking tasks
   // ---------------------------------------------------------------
   // request held until the rising edge that sees waitrequest low; read
   // data is taken at that same edge, and only then is anything released
   task bus(input logic rd, input logic [15:0] idx, input logic [15:0] d);
      begin
         @(posedge sys_clk);
         avs_address <= {idx, 2'b00};
         avs_writedata <= {16'h0000, d};
         avs_read <= rd;
         avs_write <= !rd;
         do begin
            @(posedge sys_clk);
         end while (avs_waitrequest !== 1'b0);
         q = avs_readdata[15:0];
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask

   task rdchk(input logic [15:0] idx, input logic [15:0] exp);
      begin
         bus(1'b1, idx, 16'h0000);
         `CHK(q, exp)
      end
   endtask

   task irqchk(input logic exp);
      begin
         @(negedge sys_clk);
         `CHK(irq, exp)
      end
   endtask

   task finish_test;
      begin
         $display("checks %0d errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // watchdog: the tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      finish_test;
   end

   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 18'h00000;
      avs_writedata = 32'h0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      for (k = 0; k < 5; k++) rdchk(16'h4030 + k, 16'h0000);
      $display("test reset_values done");
      // every source code on comparators one and four, always met
      for (k = 0; k < 4; k += 3) for (i = 0; i < 8; i++) begin
         bus(1'b0, 16'h4030, 16'h0000);
         bus(1'b0, 16'h4031 + k, {i[2:0], 1'b1, 12'h000});
         bus(1'b0, 16'h4030, 16'h0001 << k);
         u_adc.send(i[2:0], 12'h5a5);
         e = (i == 1 || i == 2 || i == 3 || i == 5 || i == 7 || (i == 0 && k == 3));
         rdchk(16'h4030, (16'h0001 << k) | ({15'h0, e} << (8 + k)));
      end
      $display("test source_codes done");
      for (i = 0; i < 6; i++) begin
         bus(1'b0, 16'h4033, {3'h7, dt[i][24:12]});
         rdchk(16'h4033, {3'h7, dt[i][24:12]});
         bus(1'b0, 16'h4030, 16'h0004);
         u_adc.send(3'h7, dt[i][11:0]);
         rdchk(16'h4030, 16'h0004 | ({15'h0, dexp[i]} << 10));
      end
      $display("test direction done");
      // a foreign source must leave the flag alone; disabling clears it
      bus(1'b0, 16'h4033, 16'he800);
      u_adc.send(3'h7, 12'h100);
      u_adc.send(3'h5, 12'hfff);
      rdchk(16'h4030, 16'h0404);
      bus(1'b0, 16'h4030, 16'h0000);
      u_adc.send(3'h7, 12'h100);
      rdchk(16'h4030, 16'h0000);
      $display("test enable done");
      bus(1'b0, 16'h4037, 16'h000f);
      bus(1'b0, 16'h4036, 16'h0004);
      irqchk(1'b0);
      bus(1'b0, 16'h4030, 16'h0004);
      u_adc.send(3'h7, 12'h100);
      repeat (2) @(posedge sys_clk);
      irqchk(1'b1);
      rdchk(16'h4035, 16'h0004);
      bus(1'b0, 16'h4036, 16'h0000);
      irqchk(1'b0);
      bus(1'b0, 16'h4036, 16'h0004);
      irqchk(1'b1);
      bus(1'b0, 16'h4037, 16'h0004);
      irqchk(1'b0);
      rdchk(16'h4035, 16'h0000);
      rdchk(16'h4037, 16'h0000);
      bus(1'b0, 16'h4040, 16'hffff);
      rdchk(16'h4040, 16'h0000);
      $display("test interrupt done");
      finish_test;
   end
endmodule // adtc_top_test
